// >>> verilog/sesr_pkg.sv
// Package for the SMI enable, edge status and serial FIFO mirror registers.
// Assumes a single 40 MHz system clock and a plain strobe register port.
package sesr_pkg;

   // Register offsets on the byte-wide register port.
   localparam logic [7:0] SESR_OFF_SMI_PIN_ENABLE_6 = 8'h1B;
   localparam logic [7:0] SESR_OFF_MISC_EDGE_STATUS = 8'h1C;
   localparam logic [7:0] SESR_OFF_SERIAL2_FIFO_MIR = 8'h1D;
   localparam logic [7:0] SESR_OFF_SMI_ROUTE        = 8'h30;
   localparam logic [7:0] SESR_OFF_IRQ_STATUS       = 8'h31;
   localparam logic [7:0] SESR_OFF_IRQ_MASK         = 8'h32;

   // Reset values.
   localparam logic [7:0] SESR_RST_SMI_PIN_ENABLE_6 = 8'h00;
   localparam logic [5:0] SESR_RST_MISC_EDGE_STATUS = 6'h00;
   localparam logic [7:0] SESR_RST_SERIAL2_FIFO_MIR = 8'h00;
   localparam logic [1:0] SESR_RST_SMI_ROUTE        = 2'h0;
   localparam logic [1:0] SESR_RST_IRQ              = 2'h0;

   // Field layout of the edge status register.
   localparam int SESR_EDGE_COUNT = 6;

   // Field layout of the serial FIFO control mirror.
   localparam int SESR_FIFO_ENABLE_BIT   = 0;
   localparam int SESR_RX_FIFO_RESET_BIT = 1;
   localparam int SESR_TX_FIFO_RESET_BIT = 2;
   localparam int SESR_DMA_MODE_BIT      = 3;
   localparam int SESR_RX_TRIGGER_LSB    = 6;
   localparam logic [7:0] SESR_FIFO_MIR_VALID = 8'hCF;

   // Field layout of the routing register.
   localparam int SESR_ROUTE_PIN_BIT    = 0;
   localparam int SESR_ROUTE_SERIRQ_BIT = 1;

   // Field layout of the interrupt status and mask registers.
   localparam int SESR_IRQ_EDGE_BIT = 0;
   localparam int SESR_IRQ_SMI_BIT  = 1;

   // One request on the register port.
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sesr_bus_req_t;

   // The six pins watched for either edge, bit 5 first.
   typedef struct packed {
      logic port6_pin1;
      logic port6_pin0;
      logic port4_pin3;
      logic port4_pin1;
      logic port2_pin2;
      logic port2_pin1;
   } sesr_edge_pins_t;

endpackage

// >>> verilog/sesr_regs.sv
// SMI pin enable, either-edge status and serial port 2 FIFO control mirror.
// Also holds the SMI routing, interrupt status and interrupt mask registers.
// Assumes all inputs synchronous to i_sys_clk and a master that never
// issues read and write strobes in the same cycle.
// Assumes the standby reset clears everything, while the main power or hard
// reset reaches only the FIFO control mirror.
//
// Strobed register access was left to the implementer.
`timescale 1ns/10ps

// Function
// - One enable bit per port-one pin source.
// - Enabled pending source drives status bus.
// - Disabled source never drives status bus.
// - Writing one clears edge status bit.
// - Writing zero leaves status bit unchanged.
// - Bits 0-2 set on port2/4 edges.
// - Bits 3-5 set on port4/6 edges.
// - Upper two status bits read zero.
// - Read-only mirror of serial FIFO control.
// - Mirror layout with reserved bits 5:4.
// - Enabled sources form routable group SMI.
module sesr_regs #(
   parameter int SRC_COUNT = 8
) (
   // Clock and resets.
   input  wire logic                     i_sys_clk,
   input  wire logic                     i_reset_n,
   input  wire logic                     i_main_reset_n,
   // Register port.
   input  wire sesr_pkg::sesr_bus_req_t  i_bus,
   output logic [7:0]                    o_rd_data,
   // Event sources.
   input  wire logic [SRC_COUNT-1:0]     i_port1_smi_event,
   input  wire sesr_pkg::sesr_edge_pins_t i_edge_pins,
   // Serial port 2 FIFO control write snoop.
   input  wire logic                     i_serial2_fcr_wr,
   input  wire logic [7:0]               i_serial2_fcr_data,
   // SMI outputs.
   output logic [SRC_COUNT-1:0]          o_smi_status_bus,
   output logic                          o_group_smi,
   output logic                          o_smi_output_pin_n,
   output logic                          o_smi_serirq,
   // Interrupt.
   output logic                          o_irq
);
   // Offsets, reset values and field positions of the register bank.
   import sesr_pkg::*;

   // Address match for a strobe on the register port.
   // Every write decode and the status read decode go through here, so those offsets match alike.
   function automatic logic hit(input logic strobe, input logic [7:0] addr,
                                input logic [7:0] off);
      hit = strobe && (addr == off);
   endfunction

   // Keeps the defined fields of a FIFO control byte and zeroes the reserved pair.
   // Field positions come from the package, so the mirror follows the port's layout.
   function automatic logic [7:0] fifo_ctrl_fields(input logic [7:0] raw);
      fifo_ctrl_fields                         = 8'h00;
      fifo_ctrl_fields[SESR_FIFO_ENABLE_BIT]   = raw[SESR_FIFO_ENABLE_BIT];
      fifo_ctrl_fields[SESR_RX_FIFO_RESET_BIT] = raw[SESR_RX_FIFO_RESET_BIT];
      fifo_ctrl_fields[SESR_TX_FIFO_RESET_BIT] = raw[SESR_TX_FIFO_RESET_BIT];
      fifo_ctrl_fields[SESR_DMA_MODE_BIT]      = raw[SESR_DMA_MODE_BIT];
      fifo_ctrl_fields[SESR_RX_TRIGGER_LSB+:2] = raw[SESR_RX_TRIGGER_LSB+:2];
   endfunction

   // Register state and its next values.
   logic [SRC_COUNT-1:0]        smi_pin_enable_6;
   logic [SRC_COUNT-1:0]        next_smi_pin_enable_6;
   logic [SESR_EDGE_COUNT-1:0]  misc_edge_status;
   logic [SESR_EDGE_COUNT-1:0]  next_misc_edge_status;

   // Edge detector history; primed marks that the history holds real samples.
   logic [SESR_EDGE_COUNT-1:0]  pins_prev;
   logic [SESR_EDGE_COUNT-1:0]  next_pins_prev;
   logic                        pins_primed;
   logic                        next_pins_primed;
   // Pins that changed since the last sample.
   logic [SESR_EDGE_COUNT-1:0]  edge_seen;

   // Mirror, routing and interrupt registers.
   logic [7:0]                  serial2_fifo_ctrl_mirror;
   logic [7:0]                  next_serial2_fifo_ctrl_mirror;
   logic [1:0]                  smi_route;
   logic [1:0]                  next_smi_route;
   logic [1:0]                  irq_status;
   logic [1:0]                  next_irq_status;
   logic [1:0]                  irq_mask;
   logic [1:0]                  next_irq_mask;

   // Next values of the output flops.
   logic [7:0]                  next_rd_data;
   logic [SRC_COUNT-1:0]        next_smi_status_bus;
   logic                        next_group_smi;
   logic                        next_smi_output_pin_n;
   logic                        next_smi_serirq;
   logic                        next_irq;

   // Decoded strobes of the register port.
   logic                        wr_enable;
   logic                        wr_status;
   logic                        wr_route;
   logic                        wr_mask;
   logic                        rd_irq;

   // Register port decode.
   // Strobes never overlap, so each decode can stand on its own.
   always_comb begin
      wr_enable = hit(i_bus.wr, i_bus.addr, SESR_OFF_SMI_PIN_ENABLE_6);
      wr_status = hit(i_bus.wr, i_bus.addr, SESR_OFF_MISC_EDGE_STATUS);
      wr_route  = hit(i_bus.wr, i_bus.addr, SESR_OFF_SMI_ROUTE);
      wr_mask   = hit(i_bus.wr, i_bus.addr, SESR_OFF_IRQ_MASK);
      rd_irq    = hit(i_bus.rd, i_bus.addr, SESR_OFF_IRQ_STATUS);
   end

   // Writable control registers: SMI enables, routing and interrupt mask.
   // Writes to unmapped or read-only offsets leave all of these untouched.
   always_comb begin
      next_smi_pin_enable_6 = smi_pin_enable_6;
      next_smi_route        = smi_route;
      next_irq_mask         = irq_mask;
      if (wr_enable) begin
         next_smi_pin_enable_6 = i_bus.wdata[SRC_COUNT-1:0];
      end
      if (wr_route) begin
         next_smi_route = i_bus.wdata[1:0];
      end
      if (wr_mask) begin
         next_irq_mask = i_bus.wdata[1:0];
      end
   end

   // Control registers.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         smi_pin_enable_6 <= SESR_RST_SMI_PIN_ENABLE_6[SRC_COUNT-1:0];
         smi_route        <= SESR_RST_SMI_ROUTE;
         irq_mask         <= SESR_RST_IRQ;
      end else begin
         smi_pin_enable_6 <= next_smi_pin_enable_6;
         smi_route        <= next_smi_route;
         irq_mask         <= next_irq_mask;
      end
   end

   // Either-edge detection; the first cycle after reset only primes history.
   // Without the primer, a pin that idles high would show a false edge after reset.
   always_comb begin
      // History is reloaded with the current pin levels every cycle.
      next_pins_prev   = i_edge_pins;
      next_pins_primed = 1'b1;
      edge_seen = pins_primed ? (pins_prev ^ i_edge_pins) : '0;
   end

   // Sticky status: write-one clears, an edge in the same cycle wins.
   // Positions 7:6 have no storage, so writes there have nothing to clear.
   always_comb begin
      next_misc_edge_status = misc_edge_status;
      if (wr_status) begin
         next_misc_edge_status = misc_edge_status & ~i_bus.wdata[SESR_EDGE_COUNT-1:0];
      end
      next_misc_edge_status = next_misc_edge_status | edge_seen;
   end

   // Edge history and status registers.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         pins_prev        <= '0;
         pins_primed      <= 1'b0;
         misc_edge_status <= SESR_RST_MISC_EDGE_STATUS;
      end else begin
         pins_prev        <= next_pins_prev;
         pins_primed      <= next_pins_primed;
         misc_edge_status <= next_misc_edge_status;
      end
   end

   // Mirror of the FIFO control byte written to serial port 2.
   // The port only accepts writes, so software reads the settings back here.
   always_comb begin
      next_serial2_fifo_ctrl_mirror = serial2_fifo_ctrl_mirror;
      if (i_serial2_fcr_wr) begin
         next_serial2_fifo_ctrl_mirror = fifo_ctrl_fields(i_serial2_fcr_data);
      end
   end

   // Cleared by the standby reset and by the main power or hard reset.
   // Bus writes to its offset are ignored; only the port snoop loads it.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n || !i_main_reset_n) begin
         serial2_fifo_ctrl_mirror <= SESR_RST_SERIAL2_FIFO_MIR;
      end else begin
         serial2_fifo_ctrl_mirror <= next_serial2_fifo_ctrl_mirror;
      end
   end

   // SMI status bus, group SMI and its two routes.
   // All four are registered, so they follow events and enables one cycle late.
   // The dedicated pin is active low and idles high.
   always_comb begin
      next_smi_status_bus = i_port1_smi_event & smi_pin_enable_6;
      // group and route
      // Group SMI is the OR of the gated sources.
      next_group_smi        = |next_smi_status_bus;
      next_smi_output_pin_n = !(next_group_smi && smi_route[SESR_ROUTE_PIN_BIT]);
      next_smi_serirq       = next_group_smi && smi_route[SESR_ROUTE_SERIRQ_BIT];
   end

   // SMI output flops.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_smi_status_bus   <= '0;
         o_group_smi        <= 1'b0;
         o_smi_output_pin_n <= 1'b1;
         o_smi_serirq       <= 1'b0;
      end else begin
         o_smi_status_bus   <= next_smi_status_bus;
         o_group_smi        <= next_group_smi;
         o_smi_output_pin_n <= next_smi_output_pin_n;
         o_smi_serirq       <= next_smi_serirq;
      end
   end

   // Interrupt status: sticky, cleared by reading it, new events win.
   // Bit 0 records any edge detection, bit 1 a rise of the group SMI.
   // The level uses the next mask, so it tracks a mask write without lag.
   always_comb begin
      next_irq_status = irq_status;
      if (rd_irq) begin
         next_irq_status = '0;
      end
      next_irq_status[SESR_IRQ_EDGE_BIT] = next_irq_status[SESR_IRQ_EDGE_BIT] | (|edge_seen);
      next_irq_status[SESR_IRQ_SMI_BIT]  = next_irq_status[SESR_IRQ_SMI_BIT]
                                          | (next_group_smi && !o_group_smi);
      // Level output: any status bit that its mask lets through.
      next_irq = |(next_irq_status & next_irq_mask);
   end

   // Interrupt status and level output.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         irq_status <= SESR_RST_IRQ;
         o_irq      <= 1'b0;
      end else begin
         irq_status <= next_irq_status;
         o_irq      <= next_irq;
      end
   end

   // Read data, presented in the cycle after the read strobe only.
   // Zero in every other cycle, so a stale value can never be taken for a read.
   // Registers narrower than a byte pad their upper bits with zeros.
   always_comb begin
      next_rd_data = 8'h00;
      if (i_bus.rd) begin
         case (i_bus.addr)
            SESR_OFF_SMI_PIN_ENABLE_6: begin
               next_rd_data[SRC_COUNT-1:0] = smi_pin_enable_6;
            end
            SESR_OFF_MISC_EDGE_STATUS: begin
               next_rd_data[SESR_EDGE_COUNT-1:0] = misc_edge_status;
            end
            SESR_OFF_SERIAL2_FIFO_MIR: begin
               next_rd_data = serial2_fifo_ctrl_mirror;
            end
            SESR_OFF_SMI_ROUTE: begin
               next_rd_data[1:0] = smi_route;
            end
            SESR_OFF_IRQ_STATUS: begin
               next_rd_data[1:0] = irq_status;
            end
            SESR_OFF_IRQ_MASK: begin
               next_rd_data[1:0] = irq_mask;
            end
            default: begin
               next_rd_data = 8'h00;
            end
         endcase
      end
   end

   // Read data register.
   always_ff @(posedge i_sys_clk) begin
      if (!i_reset_n) begin
         o_rd_data <= 8'h00;
      end else begin
         o_rd_data <= next_rd_data;
      end
   end

endmodule

// >>> test/sesr_regs_properties.sv
// Checker for the SMI enable, edge status and FIFO mirror registers.
// Sees only the top ports; bound to every sesr_regs instance.
`timescale 1ns/10ps
module sesr_regs_properties #(
   parameter int SRC_COUNT = 8
) (
   input wire logic                      i_sys_clk,
   input wire logic                      i_reset_n,
   input wire sesr_pkg::sesr_bus_req_t   i_bus,
   input wire logic [7:0]                o_rd_data,
   input wire logic [SRC_COUNT-1:0]      i_port1_smi_event,
   input wire sesr_pkg::sesr_edge_pins_t i_edge_pins,
   input wire logic [SRC_COUNT-1:0]      o_smi_status_bus,
   input wire logic                      o_group_smi,
   input wire logic                      o_smi_output_pin_n,
   input wire logic                      o_smi_serirq
);
   import sesr_pkg::*;
   logic [SRC_COUNT-1:0] en;
   logic [3:0]           rh;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (!i_reset_n);
   // Mirrors the enable register and the recent reset history.
   always_ff @(posedge i_sys_clk) begin
      rh <= {rh[2:0], i_reset_n};
      if (!i_reset_n) begin
         en <= '0;
      end else if (i_bus.wr && i_bus.addr == SESR_OFF_SMI_PIN_ENABLE_6) begin
         en <= i_bus.wdata[SRC_COUNT-1:0];
      end
   end
   a_enable_gate:
      assert property (o_smi_status_bus == ($past(i_port1_smi_event) & $past(en)))
      else $error("status bus differs from event and enable");
   a_group_or:
      assert property (o_group_smi == |o_smi_status_bus) else $error("group not OR of bus");
   a_pin_route:
      assert property (!o_smi_output_pin_n |-> o_group_smi) else $error("pin low without group");
   a_serirq_route:
      assert property (o_smi_serirq |-> o_group_smi) else $error("serial irq without group");
   a_status_upper:
      assert property ($past(i_bus.rd) && $past(i_bus.addr) == SESR_OFF_MISC_EDGE_STATUS
         |-> o_rd_data[7:6] == 2'h0) else $error("status upper bits set");
   a_mirror_reserved:
      assert property ($past(i_bus.rd) && $past(i_bus.addr) == SESR_OFF_SERIAL2_FIFO_MIR
         |-> o_rd_data[5:4] == 2'h0) else $error("mirror reserved bits set");
   a_edge_sets:
      assert property ($past(i_bus.rd) && $past(i_bus.addr) == SESR_OFF_MISC_EDGE_STATUS && &rh
         |-> &(o_rd_data[5:0] | ~($past(i_edge_pins, 2) ^ $past(i_edge_pins, 3))))
      else $error("edge not latched");
   a_idle_zero:
      assert property (!$past(i_bus.rd) |-> o_rd_data == 8'h00) else $error("read data not idle");
endmodule
bind sesr_regs sesr_regs_properties #(.SRC_COUNT(SRC_COUNT)) u_props (
   .i_sys_clk          (i_sys_clk),
   .i_reset_n          (i_reset_n),
   .i_bus              (i_bus),
   .o_rd_data          (o_rd_data),
   .i_port1_smi_event  (i_port1_smi_event),
   .i_edge_pins        (i_edge_pins),
   .o_smi_status_bus   (o_smi_status_bus),
   .o_group_smi        (o_group_smi),
   .o_smi_output_pin_n (o_smi_output_pin_n),
   .o_smi_serirq       (o_smi_serirq)
);

// >>> test/test_sesr_regs.sv
// Testbench for sesr_regs: register port, SMI gating, edge status, mirror, irq.
// Drives every port itself at rising edges; no partner model.
`timescale 1ns/10ps
module test_sesr_regs;
   import sesr_pkg::*;
   logic            i_sys_clk = 1'b0, i_reset_n = 1'b0, i_main_reset_n = 1'b0;
   logic            i_serial2_fcr_wr = 1'b0, o_group_smi, o_smi_output_pin_n, o_smi_serirq, o_irq;
   logic [7:0]      i_port1_smi_event = 8'h00, i_serial2_fcr_data = 8'h00;
   logic [7:0]      o_rd_data, o_smi_status_bus;
   sesr_bus_req_t   i_bus = '0;
   sesr_edge_pins_t i_edge_pins = '0;
   int              mismatches = 0, n_compared = 0, cyc = 0;
   always #12.5 i_sys_clk = ~i_sys_clk;
   sesr_regs #(.SRC_COUNT(8)) dut (
      .i_sys_clk          (i_sys_clk),
      .i_reset_n          (i_reset_n),
      .i_main_reset_n     (i_main_reset_n),
      .i_bus              (i_bus),
      .o_rd_data          (o_rd_data),
      .i_port1_smi_event  (i_port1_smi_event),
      .i_edge_pins        (i_edge_pins),
      .i_serial2_fcr_wr   (i_serial2_fcr_wr),
      .i_serial2_fcr_data (i_serial2_fcr_data),
      .o_smi_status_bus   (o_smi_status_bus),
      .o_group_smi        (o_group_smi),
      .o_smi_output_pin_n (o_smi_output_pin_n),
      .o_smi_serirq       (o_smi_serirq),
      .o_irq              (o_irq)
   );
   // Compares one byte and counts it.
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         mismatches++;
         $display("FAIL %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One-cycle register write and read.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_sys_clk);
      i_bus <= '{a, d, 1'b1, 1'b0};
      @(posedge i_sys_clk);
      i_bus.wr <= 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_sys_clk);
      i_bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge i_sys_clk);
      i_bus.rd <= 1'b0;
      #1 chk(o_rd_data, exp);
   endtask
   task automatic t_reset_values();
      rd_chk(SESR_OFF_SMI_PIN_ENABLE_6, 8'h00);
      rd_chk(SESR_OFF_MISC_EDGE_STATUS, 8'h00);
      rd_chk(SESR_OFF_SERIAL2_FIFO_MIR, 8'h00);
      rd_chk(8'h40, 8'h00);
   endtask
   // Walks one enable bit and checks gating and routing.
   task automatic t_smi_gate();
      wr(SESR_OFF_SMI_ROUTE, 8'h03);
      for (int i = 0; i < 8; i++) begin
         wr(SESR_OFF_SMI_PIN_ENABLE_6, 8'h01 << i);
         i_port1_smi_event <= ~(8'h01 << i);
         repeat (2) @(posedge i_sys_clk);
         #1 chk(o_smi_status_bus, 8'h00);
         chk({5'h00, o_group_smi, o_smi_output_pin_n, o_smi_serirq}, 8'h02);
         @(posedge i_sys_clk);
         i_port1_smi_event <= 8'hFF;
         repeat (2) @(posedge i_sys_clk);
         #1 chk(o_smi_status_bus, 8'h01 << i);
         chk({5'h00, o_group_smi, o_smi_output_pin_n, o_smi_serirq}, 8'h05);
      end
      wr(SESR_OFF_SMI_ROUTE, 8'h02);
      @(posedge i_sys_clk);
      #1 chk({5'h00, o_group_smi, o_smi_output_pin_n, o_smi_serirq}, 8'h07);
      @(posedge i_sys_clk);
      i_port1_smi_event <= 8'h00;
      rd_chk(SESR_OFF_SMI_PIN_ENABLE_6, 8'h80);
   endtask
   // Both edge directions on every pin, partial clears, edge against clear.
   task automatic t_edges();
      logic [7:0] acc;
      wr(SESR_OFF_IRQ_MASK, 8'h01);
      rd_chk(SESR_OFF_IRQ_STATUS, 8'h02);
      for (int j = 0; j < 2; j++) begin
         acc = 8'h00;
         for (int i = 0; i < 6; i++) begin
            @(posedge i_sys_clk);
            i_edge_pins <= i_edge_pins ^ (6'h01 << i);
            acc = acc | (8'h01 << i);
            rd_chk(SESR_OFF_MISC_EDGE_STATUS, acc);
         end
         if (j == 0) wr(SESR_OFF_MISC_EDGE_STATUS, 8'h3F);
      end
      chk({7'h00, o_irq}, 8'h01);
      rd_chk(SESR_OFF_IRQ_STATUS, 8'h01);
      @(posedge i_sys_clk);
      #1 chk({7'h00, o_irq}, 8'h00);
      wr(SESR_OFF_MISC_EDGE_STATUS, 8'h15);
      rd_chk(SESR_OFF_MISC_EDGE_STATUS, 8'h2A);
      wr(SESR_OFF_MISC_EDGE_STATUS, 8'hC0);
      rd_chk(SESR_OFF_MISC_EDGE_STATUS, 8'h2A);
      @(posedge i_sys_clk);
      i_edge_pins <= i_edge_pins ^ 6'h01;
      i_bus <= '{SESR_OFF_MISC_EDGE_STATUS, 8'h3F, 1'b1, 1'b0};
      @(posedge i_sys_clk);
      i_bus.wr <= 1'b0;
      rd_chk(SESR_OFF_MISC_EDGE_STATUS, 8'h01);
   endtask
   // Captures a port write, refuses a bus write, clears on main reset.
   task automatic t_mirror();
      @(posedge i_sys_clk);
      i_serial2_fcr_wr <= 1'b1;
      i_serial2_fcr_data <= 8'hFF;
      @(posedge i_sys_clk);
      i_serial2_fcr_wr <= 1'b0;
      wr(SESR_OFF_SERIAL2_FIFO_MIR, 8'h00);
      rd_chk(SESR_OFF_SERIAL2_FIFO_MIR, 8'hCF);
      @(posedge i_sys_clk);
      i_main_reset_n <= 1'b0;
      @(posedge i_sys_clk);
      i_main_reset_n <= 1'b1;
      rd_chk(SESR_OFF_SERIAL2_FIFO_MIR, 8'h00);
      rd_chk(SESR_OFF_SMI_PIN_ENABLE_6, 8'h80);
      @(posedge i_sys_clk);
      i_serial2_fcr_wr <= 1'b1;
      i_serial2_fcr_data <= 8'hF5;
      @(posedge i_sys_clk);
      i_serial2_fcr_wr <= 1'b0;
      rd_chk(SESR_OFF_SERIAL2_FIFO_MIR, 8'hC5);
      @(posedge i_sys_clk);
      i_reset_n <= 1'b0;
      @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      rd_chk(SESR_OFF_MISC_EDGE_STATUS, 8'h00);
      rd_chk(SESR_OFF_SERIAL2_FIFO_MIR, 8'h00);
      rd_chk(SESR_OFF_SMI_PIN_ENABLE_6, 8'h00);
   endtask
   task automatic end_sim();
      $display("Counts: %0d mismatches, %0d compared", mismatches, n_compared);
      if (mismatches == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Cuts a hang short well beyond the expected run of under 200 cycles.
   always @(posedge i_sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         $display("FAIL %0t: timeout", $time);
         mismatches++;
         end_sim();
      end
   end
   initial begin
      repeat (4) @(posedge i_sys_clk);
      i_reset_n <= 1'b1;
      i_main_reset_n <= 1'b1;
      t_reset_values();
      t_smi_gate();
      t_edges();
      t_mirror();
      end_sim();
   end
endmodule
